// [design/bsr_regs.vh]
`ifndef BSR_REGS_VH
`define BSR_REGS_VH
// Mode select codes {mode_select_high, mode_select_low}
`define BSR_MODE_HOLD  2'h0
`define BSR_MODE_RIGHT 2'h1
`define BSR_MODE_LEFT  2'h2
`define BSR_MODE_LOAD  2'h3
// Register width and clear value
`define BSR_WIDTH      4
`define BSR_CLEAR_VAL  4'h0
// Sample FIFO geometry
`define BSR_FIFO_DEPTH 16
`define BSR_FIFO_AW    4
`endif

// [design/bsr_shift_reg.v]
`timescale 1ns/100ps
`include "bsr_regs.vh"

////////////////////////////////////////////////////////////////////////////
// Small synchronous FIFO with valid/ready on both sides
module bsr_fifo
#(
   parameter WIDTH = 4,
   parameter DEPTH = 16,
   parameter AW    = 4
)
(
   // Clock and reset
   input  wire             core_clk_in,
   input  wire             nrst_in,
   // Fill side
   input  wire             wr_valid_in,
   output wire             wr_ready_out,
   input  wire [WIDTH-1:0] wr_data_in,
   // Drain side
   output wire             rd_valid_out,
   input  wire             rd_ready_in,
   output wire [WIDTH-1:0] rd_data_out
);
   reg  [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
   reg  [AW-1:0]    wr_ptr;          // Write index
   reg  [AW-1:0]    rd_ptr;          // Read index
   reg  [AW:0]      count;           // Occupancy, one bit wider than index
   wire             do_wr;
   wire             do_rd;

   assign wr_ready_out = (count != DEPTH[AW:0]);
   assign rd_valid_out = (count != {(AW+1){1'b0}});
   assign rd_data_out  = mem[rd_ptr];
   assign do_wr        = wr_valid_in && wr_ready_out;
   assign do_rd        = rd_valid_out && rd_ready_in;

   // Storage write, no reset needed on data
   always @(posedge core_clk_in)
   begin
      if (do_wr)
      begin
         mem[wr_ptr] <= wr_data_in;
      end
   end

   // Pointers and occupancy
   always @(posedge core_clk_in)
   begin
      if (!nrst_in)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (do_wr)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         // Simultaneous read and write leaves the count alone
         if (do_wr && !do_rd)
         begin
            count <= count + 1'b1;
         end
         else if (do_rd && !do_wr)
         begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////
// Four-bit universal shift register; clear, mode, serial and parallel pins enter through synchronisers
module bsr_shift_reg
(
   // Clock and reset
   input  wire       core_clk_in,
   input  wire       nrst_in,
   // Clear, active low
   input  wire       async_clear_n_in,
   // Mode selects
   input  wire       mode_select_low_in,
   input  wire       mode_select_high_in,
   // Serial and parallel data
   input  wire       right_serial_in,
   input  wire       left_serial_in,
   input  wire [3:0] par_data_in,
   // Parallel outputs, index 0 is the first position
   output reg  [3:0] q_out,
   // Sample stream of register contents
   output reg        smp_valid_out,
   output reg  [3:0] smp_data_out,
   input  wire       smp_ready_in
);
   // Two-stage synchronisers; stage one is read only by stage two
   reg  [8:0] sync1;
   reg  [8:0] sync2;
   wire       clr_n;
   wire [1:0] mode;
   wire       ser_r;
   wire       ser_l;
   wire [3:0] pdat;
   reg  [3:0] next_q;      // Next register value
   reg        changed;     // Register value moved this edge
   wire       f_ready;     // FIFO can accept
   wire       f_valid;     // FIFO holds a sample
   wire [3:0] f_data;
   wire       f_pop;

   assign clr_n = sync2[8];
   assign mode  = sync2[7:6];
   assign ser_r = sync2[5];
   assign ser_l = sync2[4];
   assign pdat  = sync2[3:0];

   // Bring the clear, mode, serial and parallel pins into the clock domain
   always @(posedge core_clk_in)
   begin
      if (!nrst_in)
      begin
         sync1 <= 9'h000;
         sync2 <= 9'h000;
      end
      else
      begin
         sync1 <= {async_clear_n_in, mode_select_high_in, mode_select_low_in,
                   right_serial_in, left_serial_in, par_data_in};
         sync2 <= sync1;
      end
   end

   // Mode decode; clear sits above every mode
   always @*
   begin
      next_q = q_out;
      if (!clr_n)
      begin
         next_q = `BSR_CLEAR_VAL;
      end
      else
      begin
         case (mode)
            `BSR_MODE_LOAD:
            begin
               next_q = pdat;
            end
            `BSR_MODE_RIGHT:
            begin
               next_q = {q_out[2:0], ser_r};
            end
            `BSR_MODE_LEFT:
            begin
               next_q = {ser_l, q_out[3:1]};
            end
            `BSR_MODE_HOLD:
            begin
               next_q = q_out;
            end
            default:
            begin
               next_q = q_out;
            end
         endcase
      end
   end

   // State update only at the rising edge, so nothing leaks early
   // Clear is sampled, trading true asynchrony for one clock domain
   always @(posedge core_clk_in)
   begin
      if (!nrst_in)
      begin
         q_out   <= `BSR_CLEAR_VAL;
         changed <= 1'b0;
      end
      else
      begin
         q_out   <= next_q;
         changed <= (next_q != q_out);
      end
   end

   // Samples of new contents are queued; drops when full
   bsr_fifo
   #(
      .WIDTH (`BSR_WIDTH),
      .DEPTH (`BSR_FIFO_DEPTH),
      .AW    (`BSR_FIFO_AW)
   )
   u_fifo
   (
      .core_clk_in  (core_clk_in),
      .nrst_in      (nrst_in),
      .wr_valid_in  (changed),
      .wr_ready_out (f_ready),
      .wr_data_in   (q_out),
      .rd_valid_out (f_valid),
      .rd_ready_in  (f_pop),
      .rd_data_out  (f_data)
   );

   // Output skid: pop when stage empty or being taken
   assign f_pop = f_valid && (!smp_valid_out || smp_ready_in);

   // Registered stream output stage
   always @(posedge core_clk_in)
   begin
      if (!nrst_in)
      begin
         smp_valid_out <= 1'b0;
         smp_data_out  <= 4'h0;
      end
      else if (f_pop)
      begin
         smp_valid_out <= 1'b1;
         smp_data_out  <= f_data;
      end
      else if (smp_ready_in)
      begin
         smp_valid_out <= 1'b0;
      end
   end
endmodule

// [tb/bsr_props.sv]
`timescale 1ns/100ps
`include "bsr_regs.vh"
module bsr_props
(
   // Pins of the shift register
   input logic       core_clk_in,
   input logic       nrst_in,
   input logic       async_clear_n_in,
   input logic       mode_select_low_in,
   input logic       mode_select_high_in,
   input logic       right_serial_in,
   input logic       left_serial_in,
   input logic       smp_valid_out,
   input logic       smp_ready_in,
   input logic [3:0] par_data_in,
   input logic [3:0] q_out,
   input logic [3:0] smp_data_out
);
   // Edges since reset; the syncs need two to fill, the register one more
   logic [2:0] up;
   always @(posedge core_clk_in)
      up <= !nrst_in ? 3'h0 : up + {2'h0, up < 3'h4};
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   sequence s_armed;
      up == 3'h4 && $past(async_clear_n_in, 3);
   endsequence
   property p_act(m, v);
      s_armed ##0 $past({mode_select_high_in, mode_select_low_in}, 3) == m
      |-> q_out == v;
   endproperty
   a_load_data:
   assert property (p_act(`BSR_MODE_LOAD, $past(par_data_in, 3)))
      else $error("load wrong");
   a_shift_right:
   assert property (p_act(`BSR_MODE_RIGHT,
      {$past(q_out[2:0]), $past(right_serial_in, 3)})) else $error("right");
   a_shift_left:
   assert property (p_act(`BSR_MODE_LEFT,
      {$past(left_serial_in, 3), $past(q_out[3:1])})) else $error("left");
   a_hold_mode:
   assert property (p_act(`BSR_MODE_HOLD, $past(q_out))) else $error("hold");
   a_clear_low:
   assert property (up == 3'h4 && !$past(async_clear_n_in, 3) |-> q_out == 4'h0)
      else $error("clear");
   a_clear_held:
   assert property (!async_clear_n_in [*4] |-> ##3 q_out == 4'h0)
      else $error("clear held");
   a_smp_hold:
   assert property (smp_valid_out && !smp_ready_in |=> smp_valid_out &&
      $stable(smp_data_out)) else $error("sample dropped");
   a_smp_follow:
   assert property ($changed(q_out) |-> ##[1:40] smp_valid_out)
      else $error("no sample");
endmodule
bind bsr_shift_reg bsr_props u_props (.*);

// [tb/bsr_sink.sv]
`timescale 1ns/100ps
// Sample consumer; stalls on demand so the FIFO can fill
module bsr_sink
(
   input  wire       core_clk_in,
   input  wire       stall_in,
   input  wire       smp_valid_out,
   input  wire [3:0] smp_data_out,
   output wire       smp_ready_in,
   output reg  [4:0] n_got = 5'h0,
   output reg  [3:0] first
);
   assign smp_ready_in = !stall_in;
   // Count accepted samples, keep the oldest
   always @(posedge core_clk_in)
      if (smp_valid_out && smp_ready_in)
      begin
         if (n_got == 5'h0)
            first <= smp_data_out;
         n_got <= n_got + 5'h1;
      end
endmodule

// [tb/tb.sv]
`timescale 1ns/100ps
`include "bsr_regs.vh"
module tb;
   logic core_clk_in = 1'b0, nrst_in = 1'b0;
   logic async_clear_n_in = 1'b1, stall_in = 1'b1;
   logic mode_select_low_in = 1'b0, mode_select_high_in = 1'b0;
   logic right_serial_in = 1'b0, left_serial_in = 1'b0;
   logic smp_ready_in, smp_valid_out;
   logic [3:0] par_data_in = 4'h0, q_out, smp_data_out, e = 4'h0, first;
   logic [4:0] n_got;
   int n_errors = 0, checked = 0;
   bsr_shift_reg dut (.*);
   bsr_sink u_sink (.*);
   always #10 core_clk_in = ~core_clk_in;
   task chk(input logic [3:0] a, b);
      checked++;
      if (a !== b)
      begin
         n_errors++;
         $display("[ERR] %0t seen %h want %h", $time, a, b);
      end
   endtask
   // One mode for one edge, then hold with the data moving
   task op(input logic [1:0] m, input logic [3:0] d, input logic r, l);
      @(posedge core_clk_in);
      {mode_select_high_in, mode_select_low_in} <= m;
      {par_data_in, right_serial_in, left_serial_in} <= {d, r, l};
      case (m)
         `BSR_MODE_LOAD:  e = d;
         `BSR_MODE_RIGHT: e = {e[2:0], r};
         `BSR_MODE_LEFT:  e = {l, e[3:1]};
         default:         e = e;
      endcase
      @(posedge core_clk_in);
      {mode_select_high_in, mode_select_low_in} <= `BSR_MODE_HOLD;
      par_data_in <= ~d;
      repeat (3) @(posedge core_clk_in);
      #1;
   endtask
   // Twenty changes into a stalled sink, then drain
   task t_fifo;
      for (int i = 0; i < 20; i++)
         op(`BSR_MODE_RIGHT, 4'h0, !i[0], 1'b0);
      @(posedge core_clk_in);
      stall_in <= 1'b0;
      repeat (40) @(posedge core_clk_in);
      #1;
      chk(first, 4'h1);
      chk({3'h0, n_got > 5'hf && n_got < 5'h12}, 4'h1);
   endtask
   task t_modes;
      op(`BSR_MODE_LOAD, 4'h6, 1'b1, 1'b1);
      chk(q_out, e);
      op(`BSR_MODE_RIGHT, 4'h3, 1'b1, 1'b0);
      chk(q_out, e);
      op(`BSR_MODE_LEFT, 4'h3, 1'b0, 1'b0);
      chk(q_out, e);
      op(`BSR_MODE_HOLD, 4'hf, 1'b1, 1'b1);
      chk(q_out, e);
   endtask
   // Clear wins over a load that is asked for meanwhile
   task t_clear;
      @(posedge core_clk_in);
      async_clear_n_in <= 1'b0;
      {mode_select_high_in, mode_select_low_in} <= `BSR_MODE_LOAD;
      par_data_in <= 4'hf;
      repeat (6) @(posedge core_clk_in);
      #1;
      chk(q_out, 4'h0);
      @(posedge core_clk_in);
      async_clear_n_in <= 1'b1;
      {mode_select_high_in, mode_select_low_in} <= `BSR_MODE_HOLD;
      repeat (4) @(posedge core_clk_in);
      #1;
      chk(q_out, 4'h0);
   endtask
   task give_verdict;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      t_fifo;
      t_modes;
      t_clear;
      give_verdict;
   end
   initial
   begin
      #20000;
      n_errors++;
      give_verdict;
   end
endmodule
